/* File: shared/astr_consts.vh */
`ifndef ASTR_CONSTS_VH
`define ASTR_CONSTS_VH
// ==========================================
// Register offsets
`define ASTR_OFS_IRQ_FLAGS   8'h0C
`define ASTR_OFS_RX_STATUS   8'h18
`define ASTR_OFS_TX_HOLD     8'h19
`define ASTR_OFS_RX_DATA     8'h1A
`define ASTR_OFS_IRQ_ENABLES 8'h8C
`define ASTR_OFS_TX_STATUS   8'h98
`define ASTR_OFS_BAUD_DIV    8'h99
// ==========================================
// Field positions
`define ASTR_IRQ_RXAVAIL     5
`define ASTR_IRQ_TXEMPTY     4
`define ASTR_RX_PORT_EN      7
`define ASTR_RX_NINE_SEL     6
`define ASTR_RX_CONT_EN      4
`define ASTR_RX_FRAME_ERR    2
`define ASTR_RX_OVERRUN      1
`define ASTR_RX_NINTH        0
`define ASTR_TX_NINE_SEL     6
`define ASTR_TX_EN           5
`define ASTR_TX_SYNC         4
`define ASTR_TX_HIGH_SPEED   2
`define ASTR_TX_SHIFT_EMPTY  1
`define ASTR_TX_NINTH        0
// ==========================================
// Reset values
`define ASTR_RST_TX_STATUS   8'h02
`define ASTR_RST_BYTE        8'h00
// ==========================================
// Timing counts, in oversampling ticks; the prescale count is in baud ticks
`define ASTR_OVS_LOW         4'hF
`define ASTR_OVS_HIGH_X4     2'h3
`define ASTR_SAMPLE_A        4'h6
`define ASTR_SAMPLE_B        4'h7
`define ASTR_SAMPLE_C        4'h8
`define ASTR_HIGH_PRESCALE   2'h3
`endif

/* File: src/astr_serial_port.v */
// Contract
// - Shift register loads only after previous stop bit is fully sent
// - Buffer-to-shifter move takes one cycle, then empty flag sets
// - Buffer-empty flag ignores interrupt enable; cleared only by buffer write
// - Read-only shifter-empty status bit, no interrupt
// - Setting transmit enable sets buffer-empty flag
// - Frame starts only with buffer written and a baud shift tick
// - Clearing transmit enable aborts frame and releases the pin
// - Nine-bit select sends ninth bit after eight data bits
// - Receive pin sampled by x16 oversampler feeding bit shifter
// - Receiver accepts frames only while continuous receive enabled
// - After stop bit, word moves to FIFO if room; flag sets
// - Data-available flag read-only, clears when FIFO read empty
// - Two-entry receive FIFO, reads return arrival order
// - Full FIFO at third stop bit sets overrun, drops word
// - Overrun clears only by toggling continuous receive enable
// - Overrun blocks all transfers into the FIFO
// - Stop bit sampled low sets framing error for that word
// - Framing error and ninth bit queue with each FIFO entry
// - Nine-bit receive select captures ninth bit per frame
// - NRZ frames: start, 8 or 9 data LSB first, one stop
// - Low speed: majority of samples seven, eight and nine
// - Baud generator gives x16 or x64 clock; halts in sleep
`timescale 1ns/10ps
`default_nettype none
`include "astr_consts.vh"

module astr_serial_port #(
    parameter DATA_W = 8                 // Data byte width
) (
    input  wire        i_clock,          // System clock
    input  wire        i_reset,          // Synchronous reset, high
    input  wire        i_clk_en,         // Clock enable, freezes state
    input  wire        i_sleep,          // Sleep request, halts baud
    input  wire [7:0]  i_addr,           // Register address
    input  wire [7:0]  i_wdata,          // Write data
    input  wire        i_wr,             // Write strobe
    input  wire        i_rd,             // Read strobe
    output reg  [7:0]  o_rdata,          // Read data, cycle after read
    input  wire        i_serial_rx_pin,  // Receive line
    output reg         o_serial_tx_pin,  // Transmit line level
    output reg         o_serial_tx_oe,   // Transmit pin driven
    output reg         o_irq             // Interrupt request level
);

    // ==========================================
    // Registers
    reg [7:0]        baud_divisor_r;
    reg [7:0]        irq_en_r;
    reg              port_en_r, rx_nine_sel_r, cont_rx_en_r, overrun_r;
    reg              tx_nine_sel_r, tx_en_r, sync_r, high_speed_r, tx_ninth_r;
    reg [DATA_W-1:0] tx_hold_r;
    reg              tx_hold_full_r;
    reg              tx_empty_flag_r;

    // Decodes a register access
    function hit;
        input [7:0] a;
        input [7:0] ofs;
        begin
            hit = (a == ofs);
        end
    endfunction

    // Register decode
    wire wr_txhold = i_wr && hit(i_addr, `ASTR_OFS_TX_HOLD);
    wire rd_rxdata = i_rd && hit(i_addr, `ASTR_OFS_RX_DATA);
    wire wr_txstat = i_wr && hit(i_addr, `ASTR_OFS_TX_STATUS);
    wire wr_rxstat = i_wr && hit(i_addr, `ASTR_OFS_RX_STATUS);

    // ==========================================
    // Baud generator
    reg [7:0] baud_cnt_r;
    reg [1:0] pre_r;
    reg       ovs_tick_r;
    wire      baud_run = port_en_r && (tx_en_r || cont_rx_en_r) && !i_sleep;

    always @(posedge i_clock) begin
        if (i_reset) begin
            baud_cnt_r <= 8'h00;
            pre_r      <= 2'h0;
            ovs_tick_r <= 1'b0;
        end else if (i_clk_en) begin
            ovs_tick_r <= 1'b0;
            // Held at the reload value while stopped, so ticks restart in phase
            if (!baud_run) begin
                baud_cnt_r <= baud_divisor_r;
                pre_r      <= 2'h0;
            end else if (baud_cnt_r == 8'h00) begin
                baud_cnt_r <= baud_divisor_r;
                pre_r      <= pre_r + 2'h1;
                // High speed: every tick is x16; low: every fourth is x16
                if (high_speed_r || pre_r == `ASTR_HIGH_PRESCALE)
                    ovs_tick_r <= 1'b1;
            end else begin
                baud_cnt_r <= baud_cnt_r - 8'h01;
            end
        end
    end

    // ==========================================
    // Transmitter
    reg [9:0] tx_shift_reg_r;
    reg [3:0] tx_bits_r;
    reg [3:0] tx_ovs_r;
    reg       tx_busy_r;

    always @(posedge i_clock) begin
        if (i_reset) begin
            tx_shift_reg_r  <= 10'h3FF;
            tx_bits_r       <= 4'h0;
            tx_ovs_r        <= 4'h0;
            tx_busy_r       <= 1'b0;
            o_serial_tx_pin <= 1'b1;
            o_serial_tx_oe  <= 1'b0;
        end else if (i_clk_en) begin
            o_serial_tx_oe <= port_en_r && tx_en_r;
            // Disabling aborts at once; the holding buffer keeps its word
            if (!tx_en_r || !port_en_r) begin
                tx_busy_r       <= 1'b0;
                o_serial_tx_pin <= 1'b1;
            end else if (!tx_busy_r) begin
                o_serial_tx_pin <= 1'b1;
                if (tx_hold_full_r && ovs_tick_r) begin
                    tx_shift_reg_r  <= {1'b1, tx_ninth_r, tx_hold_r};
                    tx_bits_r       <= tx_nine_sel_r ? 4'hB : 4'hA;
                    tx_ovs_r        <= `ASTR_OVS_LOW;
                    tx_busy_r       <= 1'b1;
                    o_serial_tx_pin <= 1'b0;
                end
            end else if (ovs_tick_r) begin
                tx_ovs_r <= tx_ovs_r - 4'h1;
                if (tx_ovs_r == 4'h0) begin
                    tx_ovs_r <= `ASTR_OVS_LOW;
                    if (tx_bits_r == 4'h1) begin
                        tx_busy_r <= 1'b0;
                    end else begin
                        // In eight-bit frames the slot after bit seven is the stop bit
                        o_serial_tx_pin <= tx_nine_sel_r || tx_bits_r != 4'h2 ?
                                           tx_shift_reg_r[0] : 1'b1;
                        tx_shift_reg_r  <= {1'b1, tx_shift_reg_r[9:1]};
                    end
                    tx_bits_r <= tx_bits_r - 4'h1;
                end
            end
        end
    end

    // Same load condition as the shifter, seen by the flag logic
    wire tx_load = tx_en_r && port_en_r && !tx_busy_r && tx_hold_full_r && ovs_tick_r;

    // ==========================================
    // Receiver
    // Two-stage line sampler; only the second stage is read
    reg [1:0]        rx_sync_r;
    reg [3:0]        rx_ovs_r;
    reg [3:0]        rx_bits_r;
    reg              rx_busy_r;
    reg [2:0]        rx_votes_r;
    reg [8:0]        rx_shift_reg_r;
    reg              rx_done_r;
    reg              rx_stop_r;
    reg [9:0]        fifo_mem [0:1];
    reg              fifo_rd_ptr_r, fifo_wr_ptr_r;
    reg [1:0]        fifo_cnt_r;
    reg              cont_rx_q_r;
    wire             rx_pin = rx_sync_r[1];
    wire             vote = (rx_votes_r[0] & rx_votes_r[1]) |
                            (rx_votes_r[1] & rx_votes_r[2]) |
                            (rx_votes_r[0] & rx_votes_r[2]);
    wire [3:0]       rx_last = rx_nine_sel_r ? 4'hA : 4'h9;

    always @(posedge i_clock) begin
        if (i_reset) begin
            rx_sync_r      <= 2'h3;
            rx_ovs_r       <= 4'h0;
            rx_bits_r      <= 4'h0;
            rx_busy_r      <= 1'b0;
            rx_votes_r     <= 3'h7;
            rx_shift_reg_r <= 9'h000;
            rx_done_r      <= 1'b0;
            rx_stop_r      <= 1'b1;
        end else if (i_clk_en) begin
            rx_sync_r <= {rx_sync_r[0], i_serial_rx_pin};
            rx_done_r <= 1'b0;
            if (!cont_rx_en_r || !port_en_r) begin
                rx_busy_r <= 1'b0;
            end else if (ovs_tick_r) begin
                if (!rx_busy_r) begin
                    if (!rx_pin) begin
                        rx_busy_r <= 1'b1;
                        rx_ovs_r  <= 4'h1;
                        rx_bits_r <= 4'h0;
                    end
                end else begin
                    rx_ovs_r <= rx_ovs_r + 4'h1;
                    if (rx_ovs_r == `ASTR_SAMPLE_A)
                        rx_votes_r[0] <= rx_pin;
                    if (rx_ovs_r == `ASTR_SAMPLE_B)
                        rx_votes_r[1] <= rx_pin;
                    if (rx_ovs_r == `ASTR_SAMPLE_C)
                        rx_votes_r[2] <= rx_pin;
                    if (rx_ovs_r == `ASTR_SAMPLE_C + 4'h1) begin
                        if (rx_bits_r == 4'h0 && vote) begin
                            rx_busy_r <= 1'b0;        // False start
                        end else if (rx_bits_r == rx_last) begin
                            rx_busy_r <= 1'b0;
                            // Stop vote low marks a framing error for this word
                            rx_stop_r <= vote;
                            rx_done_r <= 1'b1;
                        end else if (rx_bits_r != 4'h0) begin
                            rx_shift_reg_r <= rx_nine_sel_r ?
                                {vote, rx_shift_reg_r[8:1]} :
                                {1'b0, vote, rx_shift_reg_r[7:1]};
                        end
                        rx_bits_r <= rx_bits_r + 4'h1;
                    end
                end
            end
        end
    end

    // Head entry: frame error, ninth bit, data byte
    wire [9:0]  fifo_head = fifo_mem[fifo_rd_ptr_r];
    // Overrun blocks every push until continuous receive is disabled
    wire        fifo_push = rx_done_r && !overrun_r && fifo_cnt_r != 2'h2;
    wire        fifo_pop  = rd_rxdata && fifo_cnt_r != 2'h0;

    always @(posedge i_clock) begin
        if (i_reset) begin
            fifo_rd_ptr_r <= 1'b0;
            fifo_wr_ptr_r <= 1'b0;
            fifo_cnt_r    <= 2'h0;
            overrun_r     <= 1'b0;
            cont_rx_q_r   <= 1'b0;
        end else if (i_clk_en) begin
            cont_rx_q_r <= cont_rx_en_r;
            if (fifo_push) begin
                fifo_mem[fifo_wr_ptr_r] <= {!rx_stop_r, rx_shift_reg_r[8],
                                            rx_shift_reg_r[7:0]} ;
                fifo_wr_ptr_r <= !fifo_wr_ptr_r;
            end
            if (fifo_pop)
                fifo_rd_ptr_r <= !fifo_rd_ptr_r;
            fifo_cnt_r <= fifo_cnt_r + {1'b0, fifo_push} - {1'b0, fifo_pop};
            // A word meeting a full FIFO sets overrun; set wins over the clear
            if (rx_done_r && fifo_cnt_r == 2'h2)
                overrun_r <= 1'b1;
            else if (cont_rx_q_r && !cont_rx_en_r)
                overrun_r <= 1'b0;
        end
    end

    // ==========================================
    // Control registers and flags
    // flag and holding buffer
    always @(posedge i_clock) begin
        if (i_reset) begin
            baud_divisor_r  <= `ASTR_RST_BYTE;
            irq_en_r        <= `ASTR_RST_BYTE;
            tx_hold_r       <= `ASTR_RST_BYTE;
            tx_hold_full_r  <= 1'b0;
            tx_empty_flag_r <= 1'b0;
            {port_en_r, rx_nine_sel_r, cont_rx_en_r} <= 3'h0;
            {tx_nine_sel_r, tx_en_r, sync_r, high_speed_r, tx_ninth_r} <= 5'h00;
            o_irq           <= 1'b0;
        end else if (i_clk_en) begin
            if (i_wr && hit(i_addr, `ASTR_OFS_BAUD_DIV))
                baud_divisor_r <= i_wdata;
            if (i_wr && hit(i_addr, `ASTR_OFS_IRQ_ENABLES))
                irq_en_r <= i_wdata;
            if (wr_rxstat) begin
                port_en_r     <= i_wdata[`ASTR_RX_PORT_EN];
                rx_nine_sel_r <= i_wdata[`ASTR_RX_NINE_SEL];
                cont_rx_en_r  <= i_wdata[`ASTR_RX_CONT_EN];
            end
            // Sync select is stored and read back only
            if (wr_txstat) begin
                tx_nine_sel_r <= i_wdata[`ASTR_TX_NINE_SEL];
                tx_en_r       <= i_wdata[`ASTR_TX_EN];
                sync_r        <= i_wdata[`ASTR_TX_SYNC];
                high_speed_r  <= i_wdata[`ASTR_TX_HIGH_SPEED];
                tx_ninth_r    <= i_wdata[`ASTR_TX_NINTH];
            end
            if (wr_txhold) begin
                tx_hold_r      <= i_wdata;
                tx_hold_full_r <= 1'b1;
            end else if (tx_load) begin
                tx_hold_full_r <= 1'b0;
            end
            // Set wins over the clear by a buffer write
            if (tx_load || (wr_txstat && i_wdata[`ASTR_TX_EN] && !tx_en_r))
                tx_empty_flag_r <= 1'b1;
            else if (wr_txhold)
                tx_empty_flag_r <= 1'b0;
            o_irq <= (tx_empty_flag_r && irq_en_r[`ASTR_IRQ_TXEMPTY]) ||
                     (fifo_cnt_r != 2'h0 && irq_en_r[`ASTR_IRQ_RXAVAIL]);
        end
    end

    // ==========================================
    // Read data
    // status readback
    always @(posedge i_clock) begin
        if (i_reset) begin
            o_rdata <= 8'h00;
        end else if (i_clk_en) begin
            o_rdata <= 8'h00;
            if (i_rd) begin
                // Status fields of an empty FIFO read as zero
                case (i_addr)
                    `ASTR_OFS_IRQ_FLAGS:
                        o_rdata <= {2'b00, fifo_cnt_r != 2'h0, tx_empty_flag_r, 4'h0};
                    `ASTR_OFS_RX_STATUS:
                        o_rdata <= {port_en_r, rx_nine_sel_r, 1'b0, cont_rx_en_r, 1'b0,
                                    fifo_head[9] & (fifo_cnt_r != 2'h0), overrun_r,
                                    fifo_head[8] & (fifo_cnt_r != 2'h0)};
                    `ASTR_OFS_TX_HOLD:     o_rdata <= tx_hold_r;
                    `ASTR_OFS_RX_DATA:
                        o_rdata <= (fifo_cnt_r != 2'h0) ? fifo_head[7:0] : 8'h00;
                    `ASTR_OFS_IRQ_ENABLES: o_rdata <= irq_en_r;
                    `ASTR_OFS_TX_STATUS:
                        o_rdata <= {1'b0, tx_nine_sel_r, tx_en_r, sync_r, 1'b0,
                                    high_speed_r, !tx_busy_r, tx_ninth_r};
                    `ASTR_OFS_BAUD_DIV:    o_rdata <= baud_divisor_r;
                    default:               o_rdata <= 8'h00;
                endcase
            end
        end
    end

endmodule // astr_serial_port
`default_nettype wire

/* File: verification/astr_serial_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
`include "astr_consts.vh"
// ==========================================
// Port checks of the serial port
module astr_serial_monitor (
    input wire logic       i_clock,         // Clock
    input wire logic       i_reset,         // Reset
    input wire logic [7:0] i_addr,          // Address
    input wire logic [7:0] i_wdata,         // Write data
    input wire logic       i_wr,            // Write strobe
    input wire logic       i_rd,            // Read strobe
    input wire logic [7:0] o_rdata,         // Read data
    input wire logic       o_serial_tx_pin, // Line level
    input wire logic       o_serial_tx_oe,  // Line driven
    input wire logic       o_irq            // Interrupt
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_reset);
    property p_rst_vals;
        $fell(i_reset) |-> o_serial_tx_pin && !o_serial_tx_oe && !o_irq && o_rdata == 8'h00;
    endproperty
    a_rst_vals: assert property (p_rst_vals) else $error("reset levels");
    property p_rdata_idle;
        !i_rd |=> o_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
    property p_unmapped;
        i_rd && i_addr == 8'h00 |=> o_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    property p_idle_high;
        !o_serial_tx_oe |-> o_serial_tx_pin;
    endproperty
    a_idle_high: assert property (p_idle_high) else $error("released line low");
    property p_abort;
        i_wr && i_addr == `ASTR_OFS_TX_STATUS && !i_wdata[`ASTR_TX_EN]
            |-> ##2 !o_serial_tx_oe && o_serial_tx_pin;
    endproperty
    a_abort: assert property (p_abort) else $error("abort not released");
    property p_port_off;
        i_wr && i_addr == `ASTR_OFS_RX_STATUS && !i_wdata[`ASTR_RX_PORT_EN] |-> ##2 !o_serial_tx_oe;
    endproperty
    a_port_off: assert property (p_port_off) else $error("port off but driven");
    property p_low_hold;
        o_serial_tx_oe && $fell(o_serial_tx_pin) |=> $stable(o_serial_tx_pin)[*8] ##1
            $stable(o_serial_tx_pin)[*7];
    endproperty
    a_low_hold: assert property (p_low_hold) else $error("low bit short");
    property p_irq_mask;
        i_wr && i_addr == `ASTR_OFS_IRQ_ENABLES && i_wdata == 8'h00 |-> ##2 !o_irq;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("masked irq high");
endmodule // astr_serial_monitor

bind astr_serial_port astr_serial_monitor i_mon (.i_clock(i_clock), .i_reset(i_reset),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_serial_tx_pin(o_serial_tx_pin), .o_serial_tx_oe(o_serial_tx_oe), .o_irq(o_irq));
`default_nettype wire

/* File: verification/astr_remote_node.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Remote serial node on the line
module astr_remote_node #(
    parameter int BIT_CYC = 16 // Clocks per bit
) (
    input  wire logic i_clock, // Clock
    input  wire logic i_line,  // Line from the port
    input  wire logic i_nine,  // Nine-bit frames
    output var  logic o_line   // Line to the port
);
    logic [8:0] got_word = 9'h000; // Last word heard
    int         got_count = 0;     // Words heard
    logic [8:0] w;
    always begin
        @(negedge i_line);
        w = 9'h000;
        repeat (BIT_CYC / 2) @(posedge i_clock);
        for (int i = 0; i < (i_nine ? 9 : 8); i++) begin
            repeat (BIT_CYC) @(posedge i_clock);
            w[i] = i_line;
        end
        repeat (BIT_CYC) @(posedge i_clock);
        got_word = w;
        got_count++;
    end
    // start, data LSB first, stop, idle
    task automatic send(input logic [8:0] d, input logic nine, input logic stop);
        @(posedge i_clock);
        o_line <= 1'b0;
        for (int i = 0; i <= (nine ? 9 : 8); i++) begin
            repeat (BIT_CYC) @(posedge i_clock);
            o_line <= (i == (nine ? 9 : 8)) ? stop : d[i];
        end
        repeat (BIT_CYC) @(posedge i_clock);
        o_line <= 1'b1;
        repeat (BIT_CYC) @(posedge i_clock);
    endtask
    initial o_line = 1'b1;
endmodule // astr_remote_node
`default_nettype wire

/* File: verification/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "astr_consts.vh"
module tb_top;
    logic       i_clock = 1'b0;
    logic       i_reset = 1'b1;
    logic [7:0] i_addr = 8'h00;
    logic [7:0] i_wdata = 8'h00;
    logic       i_wr = 1'b0;
    logic       i_rd = 1'b0;
    logic       nine = 1'b0;
    logic       clk_en = 1'b1;
    logic       sleep = 1'b0;
    wire  [7:0] o_rdata;
    wire        tx_pin, tx_oe, irq, rx_line, tx_line;
    int         err_count = 0;
    int         compares = 0;
    // Clock and pulled-up line
    always #50 i_clock = ~i_clock;
    assign tx_line = tx_oe ? tx_pin : 1'b1;
    astr_serial_port i_dut (.i_clock(i_clock), .i_reset(i_reset), .i_clk_en(clk_en),
        .i_sleep(sleep), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .i_serial_rx_pin(rx_line), .o_serial_tx_pin(tx_pin),
        .o_serial_tx_oe(tx_oe), .o_irq(irq));
    astr_remote_node i_rem (.i_clock(i_clock), .i_line(tx_line), .i_nine(nine),
        .o_line(rx_line));
    // ==========================================
    // Bus and compare tasks
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge i_clock);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= v;
        @(posedge i_clock);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge i_clock);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clock);
        i_rd <= 1'b0;
        #1;
        chk({1'b0, o_rdata & m}, {1'b0, e});
    endtask
    task automatic wait_rx(input int n);
        for (int k = 0; k < 4000 && i_rem.got_count < n; k++)
            @(posedge i_clock);
    endtask
    // ==========================================
    // Scenarios
    task automatic t_regs();
        rd(`ASTR_OFS_TX_STATUS, 8'hFF, `ASTR_RST_TX_STATUS);
        rd(`ASTR_OFS_IRQ_FLAGS, 8'h30, 8'h00);
        rd(8'h00, 8'hFF, 8'h00);
        wr(`ASTR_OFS_TX_STATUS, 8'h00);
        rd(`ASTR_OFS_TX_STATUS, 8'h02, 8'h02);
        wr(`ASTR_OFS_BAUD_DIV, 8'h5A);
        rd(`ASTR_OFS_BAUD_DIV, 8'hFF, 8'h5A);
        wr(`ASTR_OFS_BAUD_DIV, 8'h00);
        $display("t_regs done");
    endtask
    task automatic t_tx();
        int n;
        n = i_rem.got_count;
        wr(`ASTR_OFS_RX_STATUS, 8'h80);
        wr(`ASTR_OFS_TX_STATUS, 8'h24);
        rd(`ASTR_OFS_IRQ_FLAGS, 8'h10, 8'h10);
        wr(`ASTR_OFS_IRQ_ENABLES, 8'h10);
        repeat (3) @(posedge i_clock);
        #1 chk({8'h00, irq}, 9'h001);
        wr(`ASTR_OFS_TX_HOLD, 8'hA5);
        rd(`ASTR_OFS_IRQ_FLAGS, 8'h10, 8'h10);
        wr(`ASTR_OFS_TX_HOLD, 8'h3C);
        rd(`ASTR_OFS_IRQ_FLAGS, 8'h10, 8'h00);
        rd(`ASTR_OFS_TX_STATUS, 8'h02, 8'h00);
        wr(`ASTR_OFS_IRQ_ENABLES, 8'h00);
        wait_rx(n + 1);
        chk(i_rem.got_word, 9'h0A5);
        wait_rx(n + 2);
        chk(i_rem.got_word, 9'h03C);
        repeat (40) @(posedge i_clock);
        rd(`ASTR_OFS_TX_STATUS, 8'h02, 8'h02);
        $display("t_tx done");
    endtask
    task automatic t_tx9();
        int n;
        n = i_rem.got_count;
        nine = 1'b1;
        wr(`ASTR_OFS_TX_STATUS, 8'h45);
        wr(`ASTR_OFS_TX_HOLD, 8'h81);
        repeat (60) @(posedge i_clock);
        chk(9'(i_rem.got_count - n), 9'h000);
        wr(`ASTR_OFS_TX_STATUS, 8'h65);
        wait_rx(n + 1);
        chk(i_rem.got_word, 9'h181);
        nine = 1'b0;
        $display("t_tx9 done");
    endtask
    task automatic t_abort();
        wr(`ASTR_OFS_TX_STATUS, 8'h24);
        wr(`ASTR_OFS_TX_HOLD, 8'h00);
        repeat (40) @(posedge i_clock);
        wr(`ASTR_OFS_TX_STATUS, 8'h04);
        repeat (3) @(posedge i_clock);
        #1 chk({7'h00, tx_oe, tx_pin}, 9'h001);
        rd(`ASTR_OFS_TX_STATUS, 8'h02, 8'h02);
        wr(`ASTR_OFS_TX_STATUS, 8'h24);
        wr(`ASTR_OFS_RX_STATUS, 8'h00);
        repeat (200) @(posedge i_clock);
        wr(`ASTR_OFS_TX_STATUS, 8'h04);
        $display("t_abort done");
    endtask
    task automatic t_rx();
        wr(`ASTR_OFS_IRQ_ENABLES, 8'h20);
        wr(`ASTR_OFS_RX_STATUS, 8'h90);
        i_rem.send(9'h011, 1'b0, 1'b1);
        i_rem.send(9'h022, 1'b0, 1'b0);
        i_rem.send(9'h033, 1'b0, 1'b1);
        #1 chk({8'h00, irq}, 9'h001);
        rd(`ASTR_OFS_IRQ_FLAGS, 8'h20, 8'h20);
        rd(`ASTR_OFS_RX_STATUS, 8'h06, 8'h02);
        rd(`ASTR_OFS_RX_DATA, 8'hFF, 8'h11);
        rd(`ASTR_OFS_RX_STATUS, 8'h04, 8'h04);
        rd(`ASTR_OFS_RX_DATA, 8'hFF, 8'h22);
        rd(`ASTR_OFS_IRQ_FLAGS, 8'h20, 8'h00);
        chk({8'h00, irq}, 9'h000);
        i_rem.send(9'h044, 1'b0, 1'b1);
        rd(`ASTR_OFS_IRQ_FLAGS, 8'h20, 8'h00);
        wr(`ASTR_OFS_RX_STATUS, 8'h80);
        rd(`ASTR_OFS_RX_STATUS, 8'h02, 8'h00);
        i_rem.send(9'h055, 1'b0, 1'b1);
        rd(`ASTR_OFS_IRQ_FLAGS, 8'h20, 8'h00);
        wr(`ASTR_OFS_RX_STATUS, 8'hD0);
        i_rem.send(9'h1AB, 1'b1, 1'b1);
        rd(`ASTR_OFS_RX_STATUS, 8'h01, 8'h01);
        rd(`ASTR_OFS_RX_DATA, 8'hFF, 8'hAB);
        $display("t_rx done");
    endtask
    // ==========================================
    task automatic t_hold();
        int n;
        n = i_rem.got_count;
        @(posedge i_clock);
        clk_en <= 1'b0;
        wr(`ASTR_OFS_BAUD_DIV, 8'h33);
        clk_en <= 1'b1;
        rd(`ASTR_OFS_BAUD_DIV, 8'hFF, 8'h00);
        @(posedge i_clock);
        sleep <= 1'b1;
        wr(`ASTR_OFS_TX_STATUS, 8'h24);
        wr(`ASTR_OFS_TX_HOLD, 8'h5A);
        repeat (40) @(posedge i_clock);
        rd(`ASTR_OFS_TX_STATUS, 8'h02, 8'h02);
        @(posedge i_clock);
        sleep <= 1'b0;
        wait_rx(n + 1);
        chk(i_rem.got_word, 9'h05A);
        repeat (20) @(posedge i_clock);
        wr(`ASTR_OFS_TX_STATUS, 8'h20);
        wr(`ASTR_OFS_TX_HOLD, 8'h01);
        repeat (40) @(posedge i_clock);
        #1 chk({8'h00, tx_pin}, 9'h000);
        repeat (60) @(posedge i_clock);
        #1 chk({8'h00, tx_pin}, 9'h001);
        $display("t_hold done");
    endtask
    // ==========================================
    // Verdict and run control
    task automatic test_done();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge i_clock);
        err_count++;
        $display("BAD %0t watchdog expired", $time);
        test_done();
    end
    initial begin
        repeat (20) @(posedge i_clock);
        i_reset <= 1'b0;
        t_regs();
        t_tx();
        t_tx9();
        t_abort();
        t_rx();
        t_hold();
        test_done();
    end
endmodule // tb_top
`default_nettype wire
